// ===== tb.sv
// testbench: APB register, field and pixel path checks against a bench model
`timescale 1ns/1ps
module tb;
  import vlv_pkg::*;
  logic mclk = 0, reset_n = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic pixValid = 0, activeRegion = 0, lineStart = 0, fieldEnd = 0, oddField = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, pixOutValid_q, fieldOdd_q;
  logic [7:0] autoThreshold = 8'h90, v;
  vlv_pixel_t pixIn = '0, pixOut_q;
  vlv_fieldcfg_t fieldCfg_q;
  logic [VLV_ACC_W-1:0] gainRaise;
  integer seed = 16299;
  int vr;
  int fails = 0, num_checks = 0, cyc = 0, acc = 0, below = 0, total = 0;
  logic [7:0] mdl [0:4095] = '{default: 8'h00};
  logic [11:0] regs [7] = '{12'h044, 12'h048, 12'h04C, 12'h050, 12'h054, 12'h0CC, 12'h0D0};
  logic [15:0] expPix [$];

  initial forever #50 mclk = ~mclk;

  vlv_luma_vert_ratio_regs vlv_luma_vert_ratio_regs_i (.mclk, .reset_n, .clkEn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pixValid, .activeRegion,
    .lineStart, .fieldEnd, .oddField, .pixIn, .autoThreshold, .pixOut_q, .pixOutValid_q,
    .fieldCfg_q, .fieldOdd_q, .gainRaise);
  ////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [7:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge mclk);
    penable <= 1;
    // wait for the answer; only the bench timeout ends a hang
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (w && a != VLV_OFF_FACTORY) mdl[a] = d;
  endtask

  task automatic rdchk(logic [11:0] a);
    apb(0, a, 8'h00);
    chk("register", {24'h00_0000, mdl[a]}, rd);
  endtask

  function automatic logic [15:0] pixModel(logic [7:0] l, logic [7:0] c);
    logic [7:0] of;
    of = mdl[VLV_OFF_OFORMAT];
    if (of[6:5] != 0 && l < (4 << of[6:5])) l = 0;
    if (!of[7]) l = (l < 16) ? 8'd16 : (l > 253) ? 8'd253 : l;
    c = (c < 2) ? 8'd2 : (c > 253) ? 8'd253 : c;
    return {l, c};
  endfunction

  task automatic feed(int n, logic [7:0] base, logic [7:0] msk);
    logic [7:0] l, thr;
    thr = mdl[VLV_OFF_WCRAISE];
    thr = (thr[7:6] == 3) ? autoThreshold : 8'hC0 - {thr[7:6], 6'h00};
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      l = base + ($random(seed) & msk);
      v = $random(seed);
      pixIn <= {l, v};
      pixValid <= 1;
      activeRegion <= 1;
      lineStart <= (i == 0);
      expPix.push_back(pixModel(l, v));
      total++;
      below += (l < thr);
    end
    @(posedge mclk);
    pixValid <= 0;
    lineStart <= 0;
  endtask

  task automatic fend(logic odd);
    logic [7:0] hi, lo;
    hi = mdl[odd ? VLV_OFF_OVRHI : VLV_OFF_EVRHI];
    lo = mdl[odd ? VLV_OFF_OVRLO : VLV_OFF_EVRLO];
    if (below > total / 2) acc += mdl[VLV_OFF_WCRAISE][5:0];
    below = 0;
    total = 0;
    @(posedge mclk);
    fieldEnd <= 1;
    oddField <= odd;
    @(posedge mclk);
    fieldEnd <= 0;
    @(negedge mclk);
    chk("fieldCfg", {hi[5] ? 2'b01 : {hi[7], 1'b0}, hi[6], hi[4:0], lo}, fieldCfg_q);
    chk("fieldOdd", odd, fieldOdd_q);
    chk("gainRaise", acc, gainRaise);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(negedge mclk) begin
    if (pixOutValid_q === 1'b1) chk("pixOut", expPix.pop_front(), pixOut_q);
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    mdl[12'h044] = 8'hCF;
    mdl[12'h04C] = 8'h60;
    mdl[12'h0CC] = 8'h60;
    mdl[12'h054] = 8'h01;
    repeat (8) @(posedge mclk);
    reset_n <= 1;
    foreach (regs[i]) rdchk(regs[i]);
    apb(0, 12'h0FC, 8'h00);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
    foreach (regs[i]) begin
      v = (regs[i] == VLV_OFF_FACTORY) ? 8'h01 : $random(seed);
      if (regs[i] == VLV_OFF_OFORMAT) v[4:0] = 5'h00;
      apb(1, regs[i], v);
    end
    foreach (regs[i]) rdchk(regs[i]);
    for (int m = 0; m < 4; m++) begin
      for (int p = 0; p < 2; p++) begin
        v = $random(seed);
        apb(1, p ? VLV_OFF_OVRHI : VLV_OFF_EVRHI, {m[1], v[6], m[0], v[4:0]});
        apb(1, p ? VLV_OFF_OVRLO : VLV_OFF_EVRLO, $random(seed));
      end
      fend(m[0]);
      fend(!m[0]);
    end
    vr = (32'h0001_0000 - (2 - 1) * 512) & 32'h0000_1FFF;
    apb(1, VLV_OFF_EVRHI, {3'b000, vr[12:8]});
    apb(1, VLV_OFF_EVRLO, vr[7:0]);
    fend(0);
    // frozen clock enable: a field end must not be taken
    @(posedge mclk);
    clkEn <= 0;
    fieldEnd <= 1;
    oddField <= 1;
    @(posedge mclk);
    fieldEnd <= 0;
    clkEn <= 1;
    @(negedge mclk);
    chk("frozen fieldOdd", 0, fieldOdd_q);
    for (int f = 0; f < 8; f++) begin
      apb(1, VLV_OFF_OFORMAT, {f[2:0], 5'h00});
      apb(1, VLV_OFF_WCRAISE, $random(seed));
      feed(24, f[0] ? 8'hE0 : 8'h00, 8'h1F);
      feed(8, 8'h00, 8'hFF);
      fend(0);
    end
    repeat (4) @(posedge mclk);
    chk("pixels pending", 0, expPix.size());
    summarize();
  end
endmodule

bind vlv_luma_vert_ratio_regs vlv_luma_vert_ratio_regs_asserts vlv_luma_vert_ratio_regs_asserts_i (
  .mclk, .reset_n, .clkEn, .psel, .penable, .pwrite, .paddr, .prdata, .pixValid,
  .fieldEnd, .oddField, .pixOut_q, .pixOutValid_q, .fieldCfg_q, .fieldOdd_q, .gainRaise);

// ===== vlv_chroma_comb.sv
// chroma comb: averages chroma with the same pixel of the previous line
`timescale 1ns/1ps
module vlv_chroma_comb import vlv_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic pixValid,
  input wire logic lineStart,
  input wire logic combEnable,
  input wire logic [7:0] chromaIn,
  output logic [7:0] chromaOut_q
);

  logic [7:0] lineStore [VLV_LINE_LEN];
  logic [VLV_PIX_W-1:0] pixIdx_q;
  logic [8:0] avg;

  assign avg = {1'b0, chromaIn} + {1'b0, lineStore[pixIdx_q]};

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pixIdx_q <= '0;
    end else if (clkEn) begin
      if (lineStart) begin
        pixIdx_q <= '0;
      end else if (pixValid) begin
        pixIdx_q <= pixIdx_q + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (clkEn && pixValid && !lineStart) begin
      lineStore[pixIdx_q] <= chromaIn;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      chromaOut_q <= 8'h80;
    end else if (clkEn && pixValid) begin
      chromaOut_q <= combEnable ? avg[8:1] : chromaIn;
    end
  end

endmodule

// ===== vlv_luma_vert_ratio_regs.sv
// top: APB register bank plus luma range, coring, comb and vertical scaling controls
`timescale 1ns/1ps
module vlv_luma_vert_ratio_regs import vlv_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pixValid,
  input wire logic activeRegion,
  input wire logic lineStart,
  input wire logic fieldEnd,
  input wire logic oddField,
  input wire vlv_pixel_t pixIn,
  input wire logic [7:0] autoThreshold,
  output vlv_pixel_t pixOut_q,
  output logic pixOutValid_q,
  output vlv_fieldcfg_t fieldCfg_q,
  output logic fieldOdd_q,
  output logic [VLV_ACC_W-1:0] gainRaise
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  vlv_wcraise_t wcRaise_q;
  vlv_oformat_t oFormat_q;
  vlv_vrhi_t evrHi_q;
  vlv_vrhi_t ovrHi_q;
  logic [7:0] evrLo_q;
  logic [7:0] ovrLo_q;
  logic [7:0] factory_q;
  logic wrEn;
  logic rdHit;
  logic [7:0] rdByte;
  logic [31:0] prdata_d;
  logic [VLV_ACC_W-1:0] raiseAcc;

  assign wrEn = psel && penable && pwrite && clkEn;
  assign pready = 1'b1;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wcRaise_q <= VLV_RST_WCRAISE;
    end else if (wrEn && paddr == VLV_OFF_WCRAISE) begin
      wcRaise_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      oFormat_q <= VLV_RST_OFORMAT;
    end else if (wrEn && paddr == VLV_OFF_OFORMAT) begin
      oFormat_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      evrHi_q <= VLV_RST_VRHI;
      evrLo_q <= VLV_RST_VRLO;
      ovrHi_q <= VLV_RST_VRHI;
      ovrLo_q <= VLV_RST_VRLO;
    end else if (wrEn) begin
      case (paddr)
        VLV_OFF_EVRHI: evrHi_q <= pwdata[7:0];
        VLV_OFF_EVRLO: evrLo_q <= pwdata[7:0];
        VLV_OFF_OVRHI: ovrHi_q <= pwdata[7:0];
        VLV_OFF_OVRLO: ovrLo_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // factory mode latch: value held but never alters the datapath
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      factory_q <= VLV_FACTORY_READ;
    end else if (wrEn && paddr == VLV_OFF_FACTORY) begin
      factory_q <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path
  always_comb begin
    rdHit = 1'b1;
    case (paddr)
      VLV_OFF_WCRAISE: rdByte = wcRaise_q;
      VLV_OFF_OFORMAT: rdByte = oFormat_q;
      VLV_OFF_EVRHI: rdByte = evrHi_q;
      VLV_OFF_EVRLO: rdByte = evrLo_q;
      VLV_OFF_FACTORY: rdByte = VLV_FACTORY_READ;
      VLV_OFF_OVRHI: rdByte = ovrHi_q;
      VLV_OFF_OVRLO: rdByte = ovrLo_q;
      default: begin
        rdByte = 8'h00;
        rdHit = 1'b0;
      end
    endcase
    if (paddr == VLV_OFF_GAINSTAT) begin
      prdata_d = {20'h0_0000, raiseAcc};
      rdHit = 1'b1;
    end else begin
      prdata_d = {24'h00_0000, rdByte};
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite && clkEn) begin
      prdata <= prdata_d;
    end
  end

  assign pslverr = psel && penable && !rdHit;

  ////////////////////////////////////////////////////////////////////////
  // per-field configuration, taken at field boundaries
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fieldOdd_q <= 1'b0;
      fieldCfg_q <= '0;
    end else if (clkEn && fieldEnd) begin
      fieldOdd_q <= oddField;
      if (oddField) begin
        fieldCfg_q.combEnable <= ovrHi_q.combEnable;
        fieldCfg_q.vert_ratio <= {ovrHi_q.vert_ratio_upper, ovrLo_q};
        fieldCfg_q.vsMode <= ovrHi_q.interlace ? VLV_VS_INTERLACE :
          (ovrHi_q.vert_field_align ? VLV_VS_FIELDALIGN : VLV_VS_NONINT);
      end else begin
        fieldCfg_q.combEnable <= evrHi_q.combEnable;
        fieldCfg_q.vert_ratio <= {evrHi_q.vert_ratio_upper, evrLo_q};
        fieldCfg_q.vsMode <= evrHi_q.interlace ? VLV_VS_INTERLACE :
          (evrHi_q.vert_field_align ? VLV_VS_FIELDALIGN : VLV_VS_NONINT);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // white crush and comb
  vlv_white_crush uWhiteCrush (
    .mclk(mclk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .pixValid(pixValid),
    .activeRegion(activeRegion),
    .lumaIn(pixIn.luma),
    .fieldEnd(fieldEnd),
    .cfg(wcRaise_q),
    .autoThreshold(autoThreshold),
    .raiseAcc_q(raiseAcc)
  );

  assign gainRaise = raiseAcc;

  logic [7:0] combChroma;

  vlv_chroma_comb uComb (
    .mclk(mclk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .pixValid(pixValid),
    .lineStart(lineStart),
    .combEnable(fieldCfg_q.combEnable),
    .chromaIn(pixIn.chroma),
    .chromaOut_q(combChroma)
  );

  ////////////////////////////////////////////////////////////////////////
  // luma coring and output range; one cycle aligned with comb output
  logic [7:0] coreLim;
  logic [7:0] lumaDly_q;
  logic validDly_q;
  logic [7:0] lumaCored;
  logic [7:0] lumaClip;
  logic [7:0] chromaClip;

  always_comb begin
    case (oFormat_q.coreLimit)
      2'b01: coreLim = VLV_CORE_8;
      2'b10: coreLim = VLV_CORE_16;
      2'b11: coreLim = VLV_CORE_32;
      default: coreLim = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      lumaDly_q <= 8'h00;
      validDly_q <= 1'b0;
    end else if (clkEn) begin
      lumaDly_q <= pixIn.luma;
      validDly_q <= pixValid;
    end
  end

  always_comb begin
    lumaCored = (lumaDly_q < coreLim) ? 8'h00 : lumaDly_q;
    lumaClip = lumaCored;
    if (!oFormat_q.lumaFullRange) begin
      if (lumaCored < VLV_LUMA_MIN_LIM) begin
        lumaClip = VLV_LUMA_MIN_LIM;
      end else if (lumaCored > VLV_LUMA_MAX) begin
        lumaClip = VLV_LUMA_MAX;
      end
    end
    // chroma is limited in both modes
    if (combChroma < VLV_CHROMA_MIN) begin
      chromaClip = VLV_CHROMA_MIN;
    end else if (combChroma > VLV_CHROMA_MAX) begin
      chromaClip = VLV_CHROMA_MAX;
    end else begin
      chromaClip = combChroma;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pixOut_q <= '0;
      pixOutValid_q <= 1'b0;
    end else if (clkEn) begin
      pixOutValid_q <= validDly_q;
      if (validDly_q) begin
        pixOut_q.luma <= lumaClip;
        pixOut_q.chroma <= chromaClip;
      end
    end
  end

endmodule

// ===== vlv_luma_vert_ratio_regs_asserts.sv
// checker: port-level properties of the luma/vert_ratio control block
`timescale 1ns/1ps
module vlv_luma_vert_ratio_regs_asserts import vlv_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pixValid,
  input wire logic fieldEnd,
  input wire logic oddField,
  input wire vlv_pixel_t pixOut_q,
  input wire logic pixOutValid_q,
  input wire vlv_fieldcfg_t fieldCfg_q,
  input wire logic fieldOdd_q,
  input wire logic [VLV_ACC_W-1:0] gainRaise
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire fieldTake = fieldEnd && clkEn;
  wire rdSetup = psel && !penable && !pwrite && clkEn;
  ////////////////////////////////////////////////////////////////
  chk_factory_reads: assert property (
    rdSetup && paddr == VLV_OFF_FACTORY |=> prdata == 32'h0000_0001)
    else $error("factory register read not one");
  chk_reset_clears: assert property (
    $rose(reset_n) |-> gainRaise == '0 && fieldCfg_q == '0)
    else $error("state not cleared by reset");
  chk_cfg_at_field: assert property (
    !fieldTake |=> $stable(fieldCfg_q) && $stable(fieldOdd_q))
    else $error("field settings moved inside a field");
  chk_raise_hold: assert property (
    !fieldTake |=> $stable(gainRaise))
    else $error("raise changed inside a field");
  chk_raise_step: assert property (
    fieldTake |=> gainRaise >= $past(gainRaise) && gainRaise - $past(gainRaise) <= 12'h03F)
    else $error("raise step out of range");
  chk_parity_latch: assert property (
    fieldTake |=> fieldOdd_q == $past(oddField))
    else $error("field parity not latched");
  chk_vsmode_legal: assert property (
    fieldCfg_q.vsMode != 2'b11)
    else $error("illegal scaling mode");
  chk_chroma_range: assert property (
    pixOutValid_q |-> pixOut_q.chroma >= 8'h02 && pixOut_q.chroma <= 8'hFD)
    else $error("chroma outside limits");
  chk_pix_latency: assert property (
    pixValid && clkEn |-> ##2 pixOutValid_q)
    else $error("pixel output late");
  cover property (fieldTake && oddField);
  cover property (pixOutValid_q && pixOut_q.luma == 8'h00);
  cover property (rdSetup && paddr == VLV_OFF_FACTORY);
endmodule

// ===== vlv_pkg.sv
// package: register map, field layout, reset values and types for the luma/vert_ratio control block
//
// Contract
// - The white-crush raise control register is readable and writable at any time and resets to 0xCF.
// - Bits 7:6 pick the majority threshold: 00 three quarters, 01 half, 10 quarter, 11 automatic.
// - Once per field the six-bit raise step is added to an accumulator when most active pixels fall below the threshold.
// - The accumulated raise value sets how far the gain level is raised, the step being unsigned 0 to 63.
// - With the range bit at 0 luma is limited to 16..253 and chroma to 2..253.
// - With the range bit at 1 luma spans 0..255 while chroma stays within 2..253.
// - With coring active and luma below the limit (off, 8, 16, 32) luma is forced to zero; with the range bit at 0 the code then limits it to 16.
// - Field-align bit 7 and interlace bit 5 select scaling: 00 non-interlaced, x1 interlaced, 10 field aligned.
// - With the comb bit set chroma of adjacent lines is averaged through a line store, otherwise bypassed.
// - Separate even and odd copies of the vertical scaling registers apply to fields of matching parity.
// - Reads of the test-mode register always return 0x01.
package vlv_pkg;

  localparam logic [11:0] VLV_OFF_WCRAISE = 12'h044;
  localparam logic [11:0] VLV_OFF_OFORMAT = 12'h048;
  localparam logic [11:0] VLV_OFF_EVRHI = 12'h04C;
  localparam logic [11:0] VLV_OFF_EVRLO = 12'h050;
  localparam logic [11:0] VLV_OFF_FACTORY = 12'h054;
  localparam logic [11:0] VLV_OFF_OVRHI = 12'h0CC;
  localparam logic [11:0] VLV_OFF_OVRLO = 12'h0D0;
  localparam logic [11:0] VLV_OFF_GAINSTAT = 12'h0F0;

  localparam logic [7:0] VLV_RST_WCRAISE = 8'hCF;
  localparam logic [7:0] VLV_RST_OFORMAT = 8'h00;
  localparam logic [7:0] VLV_RST_VRHI = 8'h60;
  localparam logic [7:0] VLV_RST_VRLO = 8'h00;
  localparam logic [7:0] VLV_FACTORY_READ = 8'h01;

  localparam int VLV_ACC_W = 12;
  localparam logic [7:0] VLV_LUMA_MIN_LIM = 8'h10;
  localparam logic [7:0] VLV_LUMA_MAX = 8'hFD;
  localparam logic [7:0] VLV_CHROMA_MIN = 8'h02;
  localparam logic [7:0] VLV_CHROMA_MAX = 8'hFD;
  localparam logic [7:0] VLV_THR_3Q = 8'hC0;
  localparam logic [7:0] VLV_THR_HALF = 8'h80;
  localparam logic [7:0] VLV_THR_1Q = 8'h40;
  localparam logic [7:0] VLV_CORE_8 = 8'h08;
  localparam logic [7:0] VLV_CORE_16 = 8'h10;
  localparam logic [7:0] VLV_CORE_32 = 8'h20;
  localparam int VLV_LINE_LEN = 1024;
  localparam int VLV_PIX_W = 10;
  localparam int VLV_CNT_W = 20;

  typedef enum logic [1:0] {
    VLV_VS_NONINT = 2'b00,
    VLV_VS_INTERLACE = 2'b01,
    VLV_VS_FIELDALIGN = 2'b10
  } vlv_vsmode_t;

  typedef struct packed {
    logic [1:0] majority_threshold_sel;
    logic [5:0] white_raise_step;
  } vlv_wcraise_t;

  typedef struct packed {
    logic lumaFullRange;
    logic [1:0] coreLimit;
    logic [4:0] reserved;
  } vlv_oformat_t;

  typedef struct packed {
    logic vert_field_align;
    logic combEnable;
    logic interlace;
    logic [4:0] vert_ratio_upper;
  } vlv_vrhi_t;

  typedef struct packed {
    vlv_vsmode_t vsMode;
    logic combEnable;
    logic [12:0] vert_ratio;
  } vlv_fieldcfg_t;

  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] chroma;
  } vlv_pixel_t;

endpackage

// ===== vlv_white_crush.sv
// white-crush majority detector and per-field raise accumulator
`timescale 1ns/1ps
module vlv_white_crush import vlv_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic pixValid,
  input wire logic activeRegion,
  input wire logic [7:0] lumaIn,
  input wire logic fieldEnd,
  input wire vlv_wcraise_t cfg,
  input wire logic [7:0] autoThreshold,
  output logic [VLV_ACC_W-1:0] raiseAcc_q
);

  logic [7:0] threshold;
  logic [VLV_CNT_W-1:0] belowCnt_q;
  logic [VLV_CNT_W-1:0] totalCnt_q;
  logic majority;

  always_comb begin
    case (cfg.majority_threshold_sel)
      2'b00: threshold = VLV_THR_3Q;
      2'b01: threshold = VLV_THR_HALF;
      2'b10: threshold = VLV_THR_1Q;
      default: threshold = autoThreshold;
    endcase
  end

  assign majority = (belowCnt_q > (totalCnt_q >> 1));

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      belowCnt_q <= '0;
      totalCnt_q <= '0;
    end else if (clkEn) begin
      if (fieldEnd) begin
        belowCnt_q <= '0;
        totalCnt_q <= '0;
      end else if (pixValid && activeRegion) begin
        totalCnt_q <= totalCnt_q + 1'b1;
        if (lumaIn < threshold) begin
          belowCnt_q <= belowCnt_q + 1'b1;
        end
      end
    end
  end

  // saturating add so gain never wraps back down
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      raiseAcc_q <= '0;
    end else if (clkEn && fieldEnd && majority) begin
      if ({1'b0, raiseAcc_q} + {7'd0, cfg.white_raise_step} > {1'b0, {VLV_ACC_W{1'b1}}}) begin
        raiseAcc_q <= {VLV_ACC_W{1'b1}};
      end else begin
        raiseAcc_q <= raiseAcc_q + {6'd0, cfg.white_raise_step};
      end
    end
  end

endmodule
